// ===== rtl/lcrc_cell.sv
// Register and control logic of one programmable logic cell with its global lines.
// Operation
// - Four modes route seven data inputs.
// - Separate clock, clear and preset inputs.
// - Clock enable holds register in all modes.
// - First cell input usable as enable.
// - Clearable counter: sync clear replaces direction.
// - Two three-input lookups: bit and carry.
// - Load mux, then AND inverted sync clear.
// - Contending bus drivers resolve low.
// - Undriven bus resolves high, mux built.
// - Clear from either cluster control line.
// - Asynchronous load of third input.
// - Clear and preset active low, unused high.
// - Six asynchronous control choices.
// - Global lines from pins or logic.
// - Memory block makes own write pulse.
//
`timescale 1ns/1ns
`default_nettype none

module lcrc_cell
#(
    parameter int          MEM_ADDR_W = 8,
    parameter int          MEM_DATA_W = 8,
    parameter int          BUS_N      = lcrc_pkg::LCRC_BUS_DRIVERS,
    parameter logic [15:0] LUT_MASK   = 16'h6996
)
(
    input  wire logic                                   SYS_CLK_I,
    input  wire logic                                   RST_N_I,
    input  wire lcrc_pkg::lcrc_mode_e                   MODE_I,
    input  wire lcrc_pkg::lcrc_async_e                  ASYNC_SEL_I,
    input  wire logic                                   CLR_SEL_TWO_I,
    input  wire logic                                   EN_FROM_FIRST_I,
    input  wire logic                                   CLK_EN_I,
    input  wire logic                                   FIRST_CELL_INPUT_I,
    input  wire logic                                   SECOND_CELL_INPUT_I,
    input  wire logic                                   THIRD_CELL_INPUT_I,
    input  wire logic                                   FOURTH_CELL_INPUT_I,
    input  wire logic                                   CARRY_IN_I,
    input  wire logic                                   CASCADE_IN_I,
    input  wire logic                                   SYNC_LOAD_I,
    input  wire logic [lcrc_pkg::LCRC_GLOBAL_LINES-1:0] GLOBAL_PIN_I,
    input  wire logic [lcrc_pkg::LCRC_GLOBAL_LINES-1:0] GLOBAL_FROM_LOGIC_I,
    input  wire logic [lcrc_pkg::LCRC_GLOBAL_LINES-1:0] GLOBAL_INT_I,
    input  wire logic                                   CLK_DIV_SEL_I,
    input  wire logic [BUS_N-1:0]                       BUS_OE_I,
    input  wire logic [BUS_N-1:0]                       BUS_DATA_I,
    input  wire logic                                   MEM_WE_I,
    input  wire logic [MEM_ADDR_W-1:0]                  MEM_ADDR_I,
    input  wire logic [MEM_DATA_W-1:0]                  MEM_WDATA_I,
    output logic                                        REG_Q_O,
    output logic                                        COMB_O,
    output logic                                        CARRY_OUT_O,
    output logic                                        CASCADE_OUT_O,
    output logic                                        BUS_O,
    output logic [lcrc_pkg::LCRC_GLOBAL_LINES-1:0]      GLOBAL_O,
    output logic                                        MEM_WPULSE_O,
    output logic [MEM_DATA_W-1:0]                       MEM_RDATA_O
);
    import lcrc_pkg::*;

    // The cell is built from a handful of independent pieces: the global line
    // selection, the mode data path, the asynchronous control decode, the
    // storage cell, the emulated bus and the memory block write path. They
    // share the clock; the global lines feed the control decode and the stored bit feeds the data path.

    // Three-input lookup, indexed into an eight-entry table given by the caller.
    // A table of eight entries is one half of the four-input table, which
    // is how the arithmetic and clearable counter modes split the cell in two.
    function automatic logic lut3
    (
        input logic [7:0] tbl,
        input logic       a,
        input logic       b,
        input logic       c
    );
        lut3 = tbl[{a, b, c}];
    endfunction

    logic                  cell_q;
    logic                  div_clk;
    logic                  wpulse;
    logic [MEM_DATA_W-1:0] mem [0:(1<<MEM_ADDR_W)-1];
    logic [MEM_DATA_W-1:0] rdata;

    // Global lines come from pins or internal logic; line zero can carry a divided clock.
    // Each line chooses its own source, so one line can be a generated clear
    // while the others still come straight from their pins.
    // global line source
    wire [LCRC_GLOBAL_LINES-1:0] glob_int = {GLOBAL_INT_I[LCRC_GLOBAL_LINES-1:1],
                                             CLK_DIV_SEL_I ? div_clk : GLOBAL_INT_I[0]};
    assign GLOBAL_O = (GLOBAL_FROM_LOGIC_I & glob_int) | (~GLOBAL_FROM_LOGIC_I & GLOBAL_PIN_I);

    // Cluster control lines are taken from the first two global lines.
    // Both are active high here; the inversion to active-low clear and
    // preset happens in the asynchronous control decode below.
    wire ctrl_one = GLOBAL_O[0];
    wire ctrl_two = GLOBAL_O[1];

    // Clock enable may come from the first cell input instead of a dedicated line.
    // Enabling the register instead of gating its clock keeps every cell on
    // one clock tree, which is what keeps a synchronous design safe.
    // enable in all modes
    wire clk_en = EN_FROM_FIRST_I ? FIRST_CELL_INPUT_I : CLK_EN_I;

    // Data path per mode; counters use the register feedback as the fourth input.
    // The normal mode looks up all four data inputs and ands in the cascade.
    // mode input routing
    wire [3:0] lut_idx    = {FIRST_CELL_INPUT_I, SECOND_CELL_INPUT_I, THIRD_CELL_INPUT_I,
                             FOURTH_CELL_INPUT_I};
    wire       normal_out = LUT_MASK[lut_idx] & CASCADE_IN_I;
    wire       arith_sum  = lut3(LUT_MASK[7:0], FIRST_CELL_INPUT_I, SECOND_CELL_INPUT_I,
                                 CARRY_IN_I);
    wire       arith_cry  = lut3(LUT_MASK[15:8], FIRST_CELL_INPUT_I, SECOND_CELL_INPUT_I,
                                 CARRY_IN_I);
    // Up/down counter: direction on the cascade input toggles with the carry.
    // The direction only steers the carry passed on; the bit itself toggles
    // whenever the carry arrives, in either direction.
    wire       cnt_toggle = CARRY_IN_I;
    wire       cnt_next   = cell_q ^ cnt_toggle;
    wire       ud_carry   = CASCADE_IN_I ? (CARRY_IN_I & cell_q) : (CARRY_IN_I & ~cell_q);

    // Clearable counter: one lookup for the bit, one for the fast carry, counting up.
    // The bit table is the exclusive or of feedback and carry in, and the
    // carry table is their and, so the chain ripples like a binary counter.
    // two lookups
    wire       cc_bit     = lut3(LCRC_CC_BIT_LUT, 1'b0, cell_q, CARRY_IN_I);
    wire       cc_carry   = lut3(LCRC_CC_CARRY_LUT, 1'b0, cell_q, CARRY_IN_I);
    // The cascade input is free in this mode, so it carries the clear.
    // cascade is sync clear
    wire       is_clrcnt  = (MODE_I == LCRC_MODE_CLRCOUNT);
    wire       sync_clr   = is_clrcnt ? CASCADE_IN_I : 1'b0;

    // Load value versus counted value, then gated by the inverted synchronous clear.
    // Putting the clear after the multiplexer lets it win over a load in the same cycle.
    // load mux and clear
    wire       cnt_val    = (MODE_I == LCRC_MODE_CLRCOUNT) ? cc_bit : cnt_next;
    wire       load_mux   = SYNC_LOAD_I ? THIRD_CELL_INPUT_I : cnt_val;
    wire       cnt_d      = load_mux & ~sync_clr;

    // Selection of the register input and the combinational outputs by mode.
    // The normal mode leaves the carry chain idle; every other mode drives it.
    logic reg_d;
    logic carry_o;
    always_comb
    begin
        reg_d   = normal_out;
        carry_o = 1'b0;
        case (MODE_I)
            LCRC_MODE_NORMAL:
            begin
                reg_d   = normal_out;
                carry_o = 1'b0;
            end
            LCRC_MODE_ARITH:
            begin
                reg_d   = arith_sum;
                carry_o = arith_cry;
            end
            LCRC_MODE_UPDOWN:
            begin
                reg_d   = cnt_d;
                carry_o = ud_carry;
            end
            LCRC_MODE_CLRCOUNT:
            begin
                reg_d   = cnt_d;
                carry_o = cc_carry;
            end
            default:
            begin
                reg_d   = normal_out;
                carry_o = 1'b0;
            end
        endcase
    end
    assign COMB_O        = reg_d;
    assign CARRY_OUT_O   = carry_o;
    assign CASCADE_OUT_O = normal_out;

    // Decode of the six asynchronous choices; each helper tells whether a choice
    // uses the clear, the preset or the load path of the storage cell.
    // six choices
    // Clear path in use.
    function automatic logic uses_clear(input lcrc_async_e sel);
        case (sel)
            LCRC_ASY_CLEAR:      uses_clear = 1'b1;
            LCRC_ASY_PRESET:     uses_clear = 1'b0;
            LCRC_ASY_CLR_PRE:    uses_clear = 1'b1;
            LCRC_ASY_LOAD_CLEAR: uses_clear = 1'b1;
            LCRC_ASY_LOAD_PRE:   uses_clear = 1'b0;
            LCRC_ASY_LOAD_ONLY:  uses_clear = 1'b0;
            default:             uses_clear = 1'b0;
        endcase
    endfunction

    // Preset path in use.
    function automatic logic uses_preset(input lcrc_async_e sel);
        case (sel)
            LCRC_ASY_CLEAR:      uses_preset = 1'b0;
            LCRC_ASY_PRESET:     uses_preset = 1'b1;
            LCRC_ASY_CLR_PRE:    uses_preset = 1'b1;
            LCRC_ASY_LOAD_CLEAR: uses_preset = 1'b0;
            LCRC_ASY_LOAD_PRE:   uses_preset = 1'b1;
            LCRC_ASY_LOAD_ONLY:  uses_preset = 1'b0;
            default:             uses_preset = 1'b0;
        endcase
    endfunction

    // Load path in use.
    function automatic logic uses_load(input lcrc_async_e sel);
        case (sel)
            LCRC_ASY_CLEAR:      uses_load = 1'b0;
            LCRC_ASY_PRESET:     uses_load = 1'b0;
            LCRC_ASY_CLR_PRE:    uses_load = 1'b0;
            LCRC_ASY_LOAD_CLEAR: uses_load = 1'b1;
            LCRC_ASY_LOAD_PRE:   uses_load = 1'b1;
            LCRC_ASY_LOAD_ONLY:  uses_load = 1'b1;
            default:             uses_load = 1'b0;
        endcase
    endfunction

    // Clear and preset each have a control input of their own, beside the clock.
    // separate control inputs
    wire clr_src   = CLR_SEL_TWO_I ? ctrl_two : ctrl_one;
    wire clr_other = CLR_SEL_TWO_I ? ctrl_one : ctrl_two;
    wire clr_use   = uses_clear(ASYNC_SEL_I);
    wire pre_use   = uses_preset(ASYNC_SEL_I);
    wire has_load  = uses_load(ASYNC_SEL_I);
    wire aload     = has_load & ctrl_one;
    // Control one is taken by the load, so clear or preset moves to control two;
    // with both clear and preset, the preset takes the line that clear leaves.
    wire clr_line  = has_load ? ctrl_two : clr_src;
    wire pre_line  = has_load ? ctrl_two :
                     (ASYNC_SEL_I == LCRC_ASY_CLR_PRE) ? clr_other : clr_src;
    // An unused clear or preset is held high, so it can never act.
    // active low, unused high
    wire clr_n     = clr_use ? ~clr_line : 1'b1;
    wire pre_n     = pre_use ? ~pre_line : 1'b1;
    // Load drives clear or preset from the third input, which yields the load value.
    wire ld_clr_n  = ~(aload & ~THIRD_CELL_INPUT_I);
    wire ld_pre_n  = ~(aload & THIRD_CELL_INPUT_I);
    wire eff_clr_n = clr_n & ld_clr_n;
    wire eff_pre_n = pre_n & ld_pre_n;

    // Limitation: this is a clocked model, so a control pulse that falls
    // between two edges shows on the output but never reaches the stored
    // value; the trade buys a single clock and no asynchronous paths.
    // The physical register has asynchronous controls; modelled on the clock as
    // a level that forces the stored value every cycle and the output at once.
    // async overrides sync
    wire async_act = ~eff_clr_n | ~eff_pre_n;
    wire async_val = eff_clr_n;
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            cell_q <= LCRC_REG_RESET;
        else if (async_act)
            cell_q <= async_val;
        else if (clk_en)
            cell_q <= reg_d;
    end
    // Clear wins over preset when both act, as in the storage cell.
    assign REG_Q_O = async_act ? async_val : cell_q;

    // Divider on the system clock for an internally made global line.
    // It runs free from reset, so its phase is fixed by the end of reset.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            div_clk <= 1'b0;
        else
            div_clk <= ~div_clk;
    end

    // Emulated bus: one driver passes, contention gives low, none gives high.
    // A multiplexer never floats or fights, so the bus always has a defined
    // level and no driver can be damaged by another.
    // contention low
    logic bus_val;
    logic bus_more;
    logic bus_any;
    always_comb
    begin
        bus_val  = 1'b1;
        bus_more = 1'b0;
        bus_any  = 1'b0;
        for (int i = 0; i < BUS_N; i++)
        begin
            if (BUS_OE_I[i])
            begin
                bus_more = bus_any;
                bus_any  = 1'b1;
                bus_val  = BUS_DATA_I[i];
            end
        end
    end
    assign BUS_O = bus_more ? 1'b0 : bus_val;

    // Memory block: the write pulse is made inside from the clock, so users
    // only meet setup to that clock and never shape a write enable.
    // self-timed write
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            wpulse <= 1'b0;
        else
            wpulse <= MEM_WE_I;
    end
    assign MEM_WPULSE_O = wpulse;

    // Storage of the memory block; it has no reset, so its contents are
    // unknown until written, as in the real array.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (MEM_WE_I)
            mem[MEM_ADDR_I] <= MEM_WDATA_I;
    end

    // Registered read of the addressed place, one cycle after the address.
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            rdata <= '0;
        else
            rdata <= mem[MEM_ADDR_I];
    end
    assign MEM_RDATA_O = rdata;

endmodule

`default_nettype wire

// ===== rtl/lcrc_pkg.sv
// Package of modes, asynchronous control choices and constants for the logic cell.
package lcrc_pkg;

    // Operating modes of the cell.
    typedef enum logic [1:0] {
        LCRC_MODE_NORMAL   = 2'b00,
        LCRC_MODE_ARITH    = 2'b01,
        LCRC_MODE_UPDOWN   = 2'b10,
        LCRC_MODE_CLRCOUNT = 2'b11
    } lcrc_mode_e;

    // Asynchronous clear and preset choices.
    typedef enum logic [2:0] {
        LCRC_ASY_CLEAR      = 3'b000,
        LCRC_ASY_PRESET     = 3'b001,
        LCRC_ASY_CLR_PRE    = 3'b010,
        LCRC_ASY_LOAD_CLEAR = 3'b011,
        LCRC_ASY_LOAD_PRE   = 3'b100,
        LCRC_ASY_LOAD_ONLY  = 3'b101
    } lcrc_async_e;

    // Number of global control lines and of bus drivers.
    localparam int LCRC_GLOBAL_LINES = 4;
    localparam int LCRC_BUS_DRIVERS  = 4;
    // Lookup table width of the cell.
    localparam int LCRC_LUT_BITS     = 16;
    // Memory block write pulse length in clock cycles.
    localparam int LCRC_WR_PULSE     = 1;
    // Clearable counter tables, indexed by {0, feedback, carry in}.
    // The bit table is the exclusive or of feedback and carry in.
    localparam logic [7:0] LCRC_CC_BIT_LUT   = 8'h06;
    // The fast carry table is the and of feedback and carry in.
    localparam logic [7:0] LCRC_CC_CARRY_LUT = 8'h08;
    // Register value after reset.
    localparam logic LCRC_REG_RESET  = 1'b0;

endpackage

// ===== tb/lcrc_cell_monitor.sv
// Checker of the cell register, emulated bus and write pulse.
`timescale 1ns/1ns
`default_nettype none
module lcrc_cell_monitor
#(
    parameter int BUS_N = 4
)
(
    input wire logic                  SYS_CLK_I,
    input wire logic                  RST_N_I,
    input wire lcrc_pkg::lcrc_mode_e  MODE_I,
    input wire lcrc_pkg::lcrc_async_e ASYNC_SEL_I,
    input wire logic                  CLR_SEL_TWO_I,
    input wire logic                  EN_FROM_FIRST_I,
    input wire logic                  CLK_EN_I,
    input wire logic                  FIRST_CELL_INPUT_I,
    input wire logic                  THIRD_CELL_INPUT_I,
    input wire logic                  CARRY_IN_I,
    input wire logic                  CASCADE_IN_I,
    input wire logic                  SYNC_LOAD_I,
    input wire logic [BUS_N-1:0]      BUS_OE_I,
    input wire logic                  MEM_WE_I,
    input wire logic                  REG_Q_O,
    input wire logic                  BUS_O,
    input wire logic [3:0]            GLOBAL_O,
    input wire logic                  MEM_WPULSE_O
);
    import lcrc_pkg::*;
    // Quiet means neither cluster line asserts, so only the clocked path acts.
    wire logic en    = EN_FROM_FIRST_I ? FIRST_CELL_INPUT_I : CLK_EN_I;
    wire logic quiet = (GLOBAL_O[1:0] == 2'h0);
    wire logic cnt   = quiet && en && (MODE_I == LCRC_MODE_CLRCOUNT);
    wire logic aclr  = CLR_SEL_TWO_I ? GLOBAL_O[1] : GLOBAL_O[0];
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    a_bus_idle: assert property (BUS_OE_I == '0 |-> BUS_O)
        else $error("bus not high with no driver");
    a_bus_contend: assert property ($countones(BUS_OE_I) > 1 |-> !BUS_O)
        else $error("bus not low under contention");
    a_en_hold: assert property (quiet && !en ##1 quiet |-> $stable(REG_Q_O))
        else $error("register moved with enable low");
    a_sync_clear: assert property (cnt && CASCADE_IN_I ##1 quiet |-> !REG_Q_O)
        else $error("synchronous clear missed");
    a_sync_load: assert property (cnt && !CASCADE_IN_I && SYNC_LOAD_I ##1 quiet
        |-> REG_Q_O == $past(THIRD_CELL_INPUT_I))
        else $error("synchronous load missed");
    a_count_step: assert property (cnt && !CASCADE_IN_I && !SYNC_LOAD_I ##1 quiet
        |-> REG_Q_O == ($past(REG_Q_O) ^ $past(CARRY_IN_I)))
        else $error("counter bit wrong");
    a_async_clear: assert property (ASYNC_SEL_I == LCRC_ASY_CLEAR && aclr |-> !REG_Q_O)
        else $error("asynchronous clear missed");
    a_async_load: assert property (ASYNC_SEL_I inside {LCRC_ASY_LOAD_CLEAR,
        LCRC_ASY_LOAD_PRE, LCRC_ASY_LOAD_ONLY} && GLOBAL_O[0] && !GLOBAL_O[1]
        |-> REG_Q_O == THIRD_CELL_INPUT_I)
        else $error("asynchronous load missed");
    a_write_pulse: assert property (MEM_WE_I |=> MEM_WPULSE_O)
        else $error("write pulse missing");
    a_pulse_idle: assert property (!MEM_WE_I |=> !MEM_WPULSE_O)
        else $error("write pulse without write");
endmodule
bind lcrc_cell lcrc_cell_monitor #(.BUS_N(BUS_N)) u_mon (.*);
`default_nettype wire

// ===== tb/lcrc_cell_tb_top.sv
// Self-checking bench of the logic cell register and control logic.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) \
    begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module lcrc_cell_tb_top;
    import lcrc_pkg::*;
    logic        clk, rst_n, clr2, efirst, cen, d1, d2, d3, d4, cin, casc, sload;
    logic        we, run, q, bus, wp, exq, comb, cout, cso, divsel;
    logic [3:0]  gpin, gsrc, gint, oe, bd, gout;
    logic [7:0]  addr, wd, rd, wv [8];
    logic [31:0] r;
    lcrc_mode_e  mode;
    lcrc_async_e asel;
    int          compares, miscompares;

    lcrc_cell u_dut
    (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .MODE_I(mode), .ASYNC_SEL_I(asel),
        .CLR_SEL_TWO_I(clr2), .EN_FROM_FIRST_I(efirst), .CLK_EN_I(cen),
        .FIRST_CELL_INPUT_I(d1), .SECOND_CELL_INPUT_I(d2), .THIRD_CELL_INPUT_I(d3),
        .FOURTH_CELL_INPUT_I(d4), .CARRY_IN_I(cin), .CASCADE_IN_I(casc),
        .SYNC_LOAD_I(sload), .GLOBAL_PIN_I(gpin), .GLOBAL_FROM_LOGIC_I(gsrc),
        .GLOBAL_INT_I(gint), .CLK_DIV_SEL_I(divsel), .BUS_OE_I(oe), .BUS_DATA_I(bd),
        .MEM_WE_I(we), .MEM_ADDR_I(addr), .MEM_WDATA_I(wd), .REG_Q_O(q), .COMB_O(comb),
        .CARRY_OUT_O(cout), .CASCADE_OUT_O(cso), .BUS_O(bus), .GLOBAL_O(gout),
        .MEM_WPULSE_O(wp), .MEM_RDATA_O(rd)
    );
    lcrc_neighbours u_nb (.clk_i(clk), .run_i(run), .oe_o(oe), .data_o(bd));

    // Bus value: high when idle, low under contention, else the one driver.
    function automatic logic exp_bus(logic [3:0] o, logic [3:0] d);
        return (o == 4'h0) ? 1'b1 : (($countones(o) > 1) ? 1'b0 : |(o & d));
    endfunction

    task automatic summarize();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // A hang ends the run as a mismatch.
    initial
    begin
        #100us;
        miscompares++;
        summarize();
    end

    initial
    begin
        {rst_n, clr2, efirst, cen, d1, d2, d3, d4, cin, casc, sload, we, run, divsel} = '0;
        {gpin, gsrc, gint, addr, wd} = '0;
        mode = LCRC_MODE_NORMAL;
        asel = LCRC_ASY_CLEAR;
        compares = 0;
        miscompares = 0;
        void'($urandom(65860));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        exq = LCRC_REG_RESET;
        // Random clocked traffic; modes other than the counter only while held.
        repeat (400)
        begin
            @(posedge clk);
            if (efirst ? d1 : cen)
                exq = casc ? 1'b0 : (sload ? d3 : exq ^ cin);
            r = $urandom;
            {efirst, d1, cen, d2, d3, d4, cin, casc, sload} <= r[8:0];
            mode <= (r[8] ? r[7] : r[6]) ? LCRC_MODE_CLRCOUNT : lcrc_mode_e'(r[10:9]);
            gpin <= {r[12:11], 2'h0};
            gsrc <= {r[14:13], 2'h0};
            gint <= r[18:15];
            #1;
            `CHK("reg", exq, q)
            `CHK("bus", exp_bus(oe, bd), bus)
            `CHK("glob", (gsrc & gint) | (~gsrc & gpin), gout)
            `CHK("cso", (^{d1, d2, d3, d4}) & casc, cso)
            if (mode == LCRC_MODE_CLRCOUNT)
            begin
                `CHK("comb", (sload ? d3 : q ^ cin) & ~casc, comb)
                `CHK("cout", cin & q, cout)
            end
        end
        $display("test clocked path done");
        // Back-to-back writes, then read each place again.
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            wv[i % 8] = (i < 8) ? 8'($urandom) : wv[0];
            {we, addr, wd} <= {i < 8, 8'(i), wv[i % 8]};
            #1 `CHK("pulse", i > 0, wp)
        end
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk);
            {we, addr} <= {1'b0, 8'(i)};
            @(posedge clk);
            #1 `CHK("rdata", wv[i], rd)
        end
        $display("test memory done");
        // Line zero from the internal divider toggles on every cycle.
        @(posedge clk);
        {divsel, gsrc} <= {1'b1, 4'h1};
        @(posedge clk);
        #1 exq = gout[0];
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            #1 `CHK("div", ~exq, gout[0])
            exq = gout[0];
        end
        @(posedge clk);
        {divsel, gsrc} <= '0;
        $display("test divided line done");
        // Every asynchronous choice against every active line pattern.
        for (int s = 0; s < 6; s++)
            for (int g = 1; g < 4; g++)
            begin
                @(posedge clk);
                r = $urandom;
                {clr2, cen, d3, casc, sload} <= r[4:0];
                asel <= lcrc_async_e'(3'(s));
                gpin <= 4'(g);
                #1;
                if (s == 0 && (clr2 ? g[1] : g[0]))
                    `CHK("aclr", 1'b0, q)
                if (s >= 3 && g == 1)
                    `CHK("aload", d3, q)
            end
        $display("test asynchronous control done");
        summarize();
    end
endmodule
`default_nettype wire

// ===== tb/lcrc_neighbours.sv
// Neighbouring cells that drive the emulated internal bus.
`timescale 1ns/1ns
`default_nettype none
module lcrc_neighbours
#(
    parameter int BUS_N = 4
)
(
    input  wire logic             clk_i,
    input  wire logic             run_i,
    output var logic [BUS_N-1:0] oe_o = '0,
    output var logic [BUS_N-1:0] data_o = '0
);
    // Fresh enables each cycle, so idle, single and contending cycles all occur.
    always @(posedge clk_i)
    begin
        oe_o   <= run_i ? BUS_N'($urandom) : '0;
        data_o <= BUS_N'($urandom);
    end
endmodule
`default_nettype wire
